// *** verilog/gpio_pin_config_bank.sv ***
/*
 * gpio_pin_config_bank: configuration bytes of pins 5.3 to 6.2 with their
 * alternate-function routing, and the port 8 data register.
 * Assumes rst_b is the standby-rail power-on reset, main_reset_b a raw
 * pin combining main power-on and PCI reset, and gpio_write_value coming
 * from data registers on the same clock.
 */
//
// How it works
// - a pin is an input when its direction bit 0 is one, an output when zero.
// - bit 1 set inverts the pin's logical value, clear passes it unchanged.
// - bit 7 set drives the pin open drain, clear drives it push-pull.
// - pin 5.3 selects by bits 3:2: GPIO, second-UART transmit, infrared transmit, reserved.
// - pin 5.4 bit 2 routes the pin to the second UART data-set-ready input.
// - pin 5.5 bit 2 drives the second UART request-to-send out on the pin.
// - pin 5.6 bit 2 routes the pin to the second UART clear-to-send input.
// - pin 5.7 bit 2 drives the second UART terminal-ready out on the pin.
// - pin 6.0 selects by bits 3:2: GPIO, first indicator, either-edge interrupt 4, reserved.
// - pin 6.1 selects by bits 3:2: GPIO, second indicator, either-edge interrupt 5, reserved.
// - pin 6.2 bit 2 routes the pin to interrupt request input C.
// - port 8 data bit n maps straight to port 8 pin n on reads and writes.
// - after standby reset all port 8 pins are outputs and the data register holds F0.
//
`timescale 1ns/1ps
`default_nettype none

module gpio_pin_config_bank (
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	input  wire logic       main_reset_b,
	// register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output var  logic [7:0] reg_rdata,
	// configurable pins, index 0 = pin 5.3 ... index 7 = pin 6.2
	input  wire logic [7:0] pin_in,
	output var  logic [7:0] pin_out,
	output var  logic [7:0] pin_oe,
	input  wire logic [7:0] gpio_write_value,
	output var  logic [7:0] gpio_read_value,
	// alternate function sources
	input  wire logic       uart2_transmit,
	input  wire logic       infrared_transmit,
	input  wire logic       uart2_request_to_send_n,
	input  wire logic       uart2_terminal_ready_n,
	input  wire logic       indicator_out_first,
	input  wire logic       indicator_out_second,
	// alternate function sinks
	output var  logic       uart2_data_set_ready_n,
	output var  logic       uart2_clear_to_send_n,
	output var  logic       edge_irq4_pulse,
	output var  logic       edge_irq5_pulse,
	output var  logic       interrupt_request_input_c,
	// port 8, always outputs
	output var  logic [7:0] port8_data_bits
);

	// ----------------------------------------
	// constant tables, index 0 = pin 5.3
	// ----------------------------------------
	localparam logic [7:0][7:0] CFG_OFS = {
		gpio_cfg_pkg::OFS_PIN_6_2_CONTROL, gpio_cfg_pkg::OFS_PIN_6_1_CONTROL,
		gpio_cfg_pkg::OFS_PIN_6_0_CONTROL, gpio_cfg_pkg::OFS_PIN_5_7_CONTROL,
		gpio_cfg_pkg::OFS_PIN_5_6_CONTROL, gpio_cfg_pkg::OFS_PIN_5_5_CONTROL,
		gpio_cfg_pkg::OFS_PIN_5_4_CONTROL, gpio_cfg_pkg::OFS_PIN_5_3_CONTROL};
	localparam logic [7:0][7:0] CFG_RST = {
		gpio_cfg_pkg::RST_PIN_6_2_CONTROL, gpio_cfg_pkg::RST_PIN_6_1_CONTROL,
		gpio_cfg_pkg::RST_PIN_6_0_CONTROL, gpio_cfg_pkg::RST_PIN_5_7_CONTROL,
		gpio_cfg_pkg::RST_PIN_5_6_CONTROL, gpio_cfg_pkg::RST_PIN_5_5_CONTROL,
		gpio_cfg_pkg::RST_PIN_5_4_CONTROL, gpio_cfg_pkg::RST_PIN_5_3_CONTROL};
	// one-bit selects keep bit 3 clear, so their code can never reach 10
	localparam logic [7:0][7:0] CFG_MASK = {
		gpio_cfg_pkg::MASK_FSEL1, gpio_cfg_pkg::MASK_FSEL2,
		gpio_cfg_pkg::MASK_FSEL2, gpio_cfg_pkg::MASK_FSEL1,
		gpio_cfg_pkg::MASK_FSEL1, gpio_cfg_pkg::MASK_FSEL1,
		gpio_cfg_pkg::MASK_FSEL1, gpio_cfg_pkg::MASK_FSEL2};

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	// pin levels are independent bits; no word coherence needed
	logic [7:0] pin_sync;
	logic       main_reset_sync_b;

	sync2 #(
		.WIDTH   (8),
		.RST_VAL (32'h0000_0000)
	) u_pin_sync (
		.sys_clk  (sys_clk),
		.rst_b    (rst_b),
		.async_in (pin_in),
		.sync_out (pin_sync)
	);

	// reset value 0 keeps main-domain defaults applied until the pin is seen high
	sync2 #(
		.WIDTH   (1),
		.RST_VAL (32'h0000_0000)
	) u_main_rst_sync (
		.sys_clk  (sys_clk),
		.rst_b    (rst_b),
		.async_in (main_reset_b),
		.sync_out (main_reset_sync_b)
	);

	// ----------------------------------------
	// register file
	// ----------------------------------------
	logic [7:0][7:0] cfg_r;
	logic [7:0][7:0] cfg_nxt;
	logic [7:0]      port8_r;
	logic [7:0]      port8_nxt;
	logic [7:0]      p8_rst_en_r;
	logic [7:0]      p8_rst_en_nxt;
	logic [7:0]      rdata_nxt;

	always_comb begin
		cfg_nxt       = cfg_r;
		port8_nxt     = port8_r;
		p8_rst_en_nxt = p8_rst_en_r;
		// unmapped offsets match nothing, so their writes are dropped
		for (int i = 0; i < gpio_cfg_pkg::NUM_CFG_PINS; i++) begin
			if (reg_wr && reg_addr == CFG_OFS[i]) begin
				cfg_nxt[i] = reg_wdata & CFG_MASK[i];
			end
		end
		if (reg_wr && reg_addr == gpio_cfg_pkg::OFS_PORT8_DATA) begin
			port8_nxt = reg_wdata;
		end
		if (reg_wr && reg_addr == gpio_cfg_pkg::OFS_PORT8_RST_EN) begin
			p8_rst_en_nxt = reg_wdata;
		end
		// main reset outranks a write landing in the same cycle
		if (!main_reset_sync_b) begin
			cfg_nxt[0] = CFG_RST[0];
			port8_nxt  = (port8_nxt & ~p8_rst_en_r)
				| (gpio_cfg_pkg::RST_PORT8_DATA & p8_rst_en_r);
		end
	end

	// read data stands for one cycle only and is zero otherwise
	always_comb begin
		rdata_nxt = 8'h00;
		if (reg_rd) begin
			for (int i = 0; i < gpio_cfg_pkg::NUM_CFG_PINS; i++) begin
				if (reg_addr == CFG_OFS[i]) begin
					rdata_nxt = cfg_r[i];
				end
			end
			if (reg_addr == gpio_cfg_pkg::OFS_PORT8_DATA) begin
				rdata_nxt = port8_r;
			end
			if (reg_addr == gpio_cfg_pkg::OFS_PORT8_RST_EN) begin
				rdata_nxt = p8_rst_en_r;
			end
		end
	end

	// one async reset; main reset acts only through the next-state logic
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_r       <= CFG_RST;
			port8_r     <= gpio_cfg_pkg::RST_PORT8_DATA;
			p8_rst_en_r <= gpio_cfg_pkg::RST_PORT8_RST_EN;
			reg_rdata   <= 8'h00;
		end else begin
			cfg_r       <= cfg_nxt;
			port8_r     <= port8_nxt;
			p8_rst_en_r <= p8_rst_en_nxt;
			reg_rdata   <= rdata_nxt;
		end
	end

	// port 8 has no direction control: the pins are outputs from reset on
	assign port8_data_bits = port8_r;

	// ----------------------------------------
	// alternate function decode
	// ----------------------------------------
	gpio_cfg_pkg::alt_route_type [7:0] alt;
	logic [1:0] fsel_5_3;
	logic [1:0] fsel_6_0;
	logic [1:0] fsel_6_1;

	always_comb begin
		fsel_5_3 = cfg_r[0][gpio_cfg_pkg::FSEL_HI:gpio_cfg_pkg::FSEL_LO];
		fsel_6_0 = cfg_r[5][gpio_cfg_pkg::FSEL_HI:gpio_cfg_pkg::FSEL_LO];
		fsel_6_1 = cfg_r[6][gpio_cfg_pkg::FSEL_HI:gpio_cfg_pkg::FSEL_LO];
		// polarity stays with GPIO use; alternate signals pass as they are
		alt = '0;
		// reserved code 11 falls back to GPIO behaviour
		if (fsel_5_3 == gpio_cfg_pkg::FUNC_ALT1) begin
			alt[0] = '{out_en: 1'b1, in_en: 1'b0, value: uart2_transmit};
		end else if (fsel_5_3 == gpio_cfg_pkg::FUNC_ALT2) begin
			alt[0] = '{out_en: 1'b1, in_en: 1'b0, value: infrared_transmit};
		end
		// input functions only release the pin; the level is picked up below
		alt[1].in_en = cfg_r[1][gpio_cfg_pkg::FSEL_LO];
		if (cfg_r[2][gpio_cfg_pkg::FSEL_LO]) begin
			alt[2] = '{out_en: 1'b1, in_en: 1'b0, value: uart2_request_to_send_n};
		end
		alt[3].in_en = cfg_r[3][gpio_cfg_pkg::FSEL_LO];
		if (cfg_r[4][gpio_cfg_pkg::FSEL_LO]) begin
			alt[4] = '{out_en: 1'b1, in_en: 1'b0, value: uart2_terminal_ready_n};
		end
		if (fsel_6_0 == gpio_cfg_pkg::FUNC_ALT1) begin
			alt[5] = '{out_en: 1'b1, in_en: 1'b0, value: indicator_out_first};
		end else if (fsel_6_0 == gpio_cfg_pkg::FUNC_ALT2) begin
			alt[5].in_en = 1'b1;
		end
		if (fsel_6_1 == gpio_cfg_pkg::FUNC_ALT1) begin
			alt[6] = '{out_en: 1'b1, in_en: 1'b0, value: indicator_out_second};
		end else if (fsel_6_1 == gpio_cfg_pkg::FUNC_ALT2) begin
			alt[6].in_en = 1'b1;
		end
		alt[7].in_en = cfg_r[7][gpio_cfg_pkg::FSEL_LO];
	end

	// ----------------------------------------
	// pin cells
	// ----------------------------------------
	// one cell per pin applies direction, polarity and drive type
	gpio_cfg_pkg::pin_drive_type [7:0] drive;
	logic [7:0] read_value;

	for (genvar g = 0; g < gpio_cfg_pkg::NUM_CFG_PINS; g++) begin : g_cell
		pin_cell u_cell (
			.cfg        (cfg_r[g]),
			.alt        (alt[g]),
			.gpio_value (gpio_write_value[g]),
			.pin_level  (pin_sync[g]),
			.drive      (drive[g]),
			.read_value (read_value[g])
		);
	end

	// ----------------------------------------
	// registered pin and sink outputs
	// ----------------------------------------
	logic [7:0] pin_out_nxt;
	logic [7:0] pin_oe_nxt;
	logic       dsr_nxt;
	logic       cts_nxt;
	logic       irqc_nxt;
	logic       irq4_nxt;
	logic       irq5_nxt;
	// edge history runs while unrouted, so turning the route on gives no false pulse
	logic       lvl6_0_r;
	logic       lvl6_1_r;

	always_comb begin
		// value and enable register together so the pad sees one change
		for (int i = 0; i < gpio_cfg_pkg::NUM_CFG_PINS; i++) begin
			pin_out_nxt[i] = drive[i].out;
			pin_oe_nxt[i]  = drive[i].oe;
		end
		// unrouted modem inputs read inactive so the UART sees no line change
		dsr_nxt  = alt[1].in_en ? pin_sync[1] : 1'b1;
		cts_nxt  = alt[3].in_en ? pin_sync[3] : 1'b1;
		irqc_nxt = alt[7].in_en & pin_sync[7];
		irq4_nxt = alt[5].in_en & (pin_sync[5] ^ lvl6_0_r);
		irq5_nxt = alt[6].in_en & (pin_sync[6] ^ lvl6_1_r);
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_out_r_init();
		end else begin
			pin_out                   <= pin_out_nxt;
			pin_oe                    <= pin_oe_nxt;
			gpio_read_value           <= read_value;
			uart2_data_set_ready_n    <= dsr_nxt;
			uart2_clear_to_send_n     <= cts_nxt;
			interrupt_request_input_c <= irqc_nxt;
			edge_irq4_pulse           <= irq4_nxt;
			edge_irq5_pulse           <= irq5_nxt;
			lvl6_0_r                  <= pin_sync[5];
			lvl6_1_r                  <= pin_sync[6];
		end
	end

	// reset branch kept in one place; all constants
	task automatic pin_out_r_init();
		pin_out                   <= 8'h00;
		pin_oe                    <= 8'h00;
		gpio_read_value           <= 8'h00;
		uart2_data_set_ready_n    <= 1'b1;
		uart2_clear_to_send_n     <= 1'b1;
		interrupt_request_input_c <= 1'b0;
		edge_irq4_pulse           <= 1'b0;
		edge_irq5_pulse           <= 1'b0;
		lvl6_0_r                  <= 1'b0;
		lvl6_1_r                  <= 1'b0;
	endtask : pin_out_r_init

endmodule : gpio_pin_config_bank

`default_nettype wire

// *** pkg/gpio_cfg_pkg.sv ***
/*
 * gpio_cfg_pkg: offsets, reset values, field positions, write masks and
 * shared types of the pin configuration bank.
 * Assumes an 8-bit register port with byte offsets as listed here.
 */
package gpio_cfg_pkg;

	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int NUM_CFG_PINS = 8;
	localparam int DATA_W       = 8;
	localparam int ADDR_W       = 8;

	// ----------------------------------------
	// register offsets, index 0 is pin 5.3 ... index 7 is pin 6.2
	// ----------------------------------------
	localparam logic [7:0] OFS_PIN_5_3_CONTROL = 8'h42;
	localparam logic [7:0] OFS_PIN_5_4_CONTROL = 8'h43;
	localparam logic [7:0] OFS_PIN_5_5_CONTROL = 8'h44;
	localparam logic [7:0] OFS_PIN_5_6_CONTROL = 8'h45;
	localparam logic [7:0] OFS_PIN_5_7_CONTROL = 8'h46;
	localparam logic [7:0] OFS_PIN_6_0_CONTROL = 8'h47;
	localparam logic [7:0] OFS_PIN_6_1_CONTROL = 8'h48;
	localparam logic [7:0] OFS_PIN_6_2_CONTROL = 8'h49;
	localparam logic [7:0] OFS_PORT8_DATA      = 8'h4A;
	localparam logic [7:0] OFS_PORT8_RST_EN    = 8'h5F;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_PIN_5_3_CONTROL = 8'h00;
	localparam logic [7:0] RST_PIN_5_4_CONTROL = 8'h01;
	localparam logic [7:0] RST_PIN_5_5_CONTROL = 8'h01;
	localparam logic [7:0] RST_PIN_5_6_CONTROL = 8'h01;
	localparam logic [7:0] RST_PIN_5_7_CONTROL = 8'h01;
	localparam logic [7:0] RST_PIN_6_0_CONTROL = 8'h01;
	localparam logic [7:0] RST_PIN_6_1_CONTROL = 8'h04;
	localparam logic [7:0] RST_PIN_6_2_CONTROL = 8'h01;
	localparam logic [7:0] RST_PORT8_DATA      = 8'hF0;
	localparam logic [7:0] RST_PORT8_RST_EN    = 8'h00;

	// ----------------------------------------
	// field positions and encodings
	// ----------------------------------------
	localparam int DIR_BIT   = 0;
	localparam int POL_BIT   = 1;
	localparam int FSEL_LO   = 2;
	localparam int FSEL_HI   = 3;
	localparam int ODRAIN_BIT = 7;

	localparam logic [1:0] FUNC_GPIO = 2'h0;
	localparam logic [1:0] FUNC_ALT1 = 2'h1;
	localparam logic [1:0] FUNC_ALT2 = 2'h2;

	// writable bits: two-bit select pins and one-bit select pins
	localparam logic [7:0] MASK_FSEL2 = 8'h8F;
	localparam logic [7:0] MASK_FSEL1 = 8'h87;

	// ----------------------------------------
	// shared types
	// ----------------------------------------
	typedef struct packed {
		logic out;
		logic oe;
	} pin_drive_type;

	typedef struct packed {
		logic out_en;
		logic in_en;
		logic value;
	} alt_route_type;

endpackage : gpio_cfg_pkg

// *** verilog/sync2.sv ***
/*
 * sync2: two-flop synchroniser for a vector of levels.
 * Assumes each bit is an independent level; no word coherence.
 */
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
	parameter int          WIDTH   = 1,
	parameter logic [31:0] RST_VAL = 32'h0000_0000
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] meta_nxt;
	logic [WIDTH-1:0] sync_nxt;

	always_comb begin
		meta_nxt = async_in;
		sync_nxt = meta_r;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r   <= RST_VAL[WIDTH-1:0];
			sync_out <= RST_VAL[WIDTH-1:0];
		end else begin
			meta_r   <= meta_nxt;
			sync_out <= sync_nxt;
		end
	end

endmodule : sync2

`default_nettype wire

// *** verilog/pin_cell.sv ***
/*
 * pin_cell: drive and read logic of one configurable pin.
 * Assumes pin_level is already synchronised; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_cell (
	input  wire logic [7:0]                  cfg,
	input  wire gpio_cfg_pkg::alt_route_type alt,
	input  wire logic                        gpio_value,
	input  wire logic                        pin_level,
	output var  gpio_cfg_pkg::pin_drive_type drive,
	output var  logic                        read_value
);

	logic drv;
	logic val;

	always_comb begin
		drv = 1'b0;
		val = 1'b0;
		if (alt.out_en) begin
			drv = 1'b1;
			val = alt.value;
		end else if (!alt.in_en) begin
			drv = ~cfg[gpio_cfg_pkg::DIR_BIT];
			val = gpio_value ^ cfg[gpio_cfg_pkg::POL_BIT];
		end
		// open drain only ever pulls low; a high is left to the pull-up
		if (cfg[gpio_cfg_pkg::ODRAIN_BIT]) begin
			drive.out = 1'b0;
			drive.oe  = drv & ~val;
		end else begin
			drive.out = val;
			drive.oe  = drv;
		end
		read_value = pin_level ^ cfg[gpio_cfg_pkg::POL_BIT];
	end

endmodule : pin_cell

`default_nettype wire

// *** bench/gpio_bank_asserts.sv ***
/*
 * gpio_bank_asserts: concurrent checks on the ports of the pin configuration bank.
 * Assumes it is bound to gpio_pin_config_bank; it mirrors config writes itself.
 */
`timescale 1ns/1ps
`default_nettype none

module gpio_bank_asserts (
	input wire logic       sys_clk,
	input wire logic       rst_b,
	input wire logic       main_reset_b,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] pin_in,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] gpio_write_value,
	input wire logic       uart2_transmit,
	input wire logic       infrared_transmit,
	input wire logic       uart2_request_to_send_n,
	input wire logic       uart2_terminal_ready_n,
	input wire logic       indicator_out_first,
	input wire logic       indicator_out_second,
	input wire logic       uart2_data_set_ready_n,
	input wire logic       uart2_clear_to_send_n,
	input wire logic       edge_irq4_pulse,
	input wire logic       interrupt_request_input_c,
	input wire logic [7:0] port8_data_bits
);
	localparam logic [7:0] OUT1 = 8'h75;
	localparam logic [7:0] IN1  = 8'h8A;
	logic [7:0] cfg_s [8];
	logic [1:0] mr_s;
	logic [7:0] altv, eo, ee, eo_r, ee_r;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	// ----------------------------------------
	// shadow config and expected pin drive
	// ----------------------------------------
	assign altv = {1'b0, indicator_out_second, indicator_out_first, uart2_terminal_ready_n,
		1'b0, uart2_request_to_send_n, 1'b0, uart2_transmit};

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_s <= '{8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h04, 8'h01};
			mr_s  <= 2'h0;
			eo_r  <= 8'h00;
			ee_r  <= 8'h00;
		end else begin
			mr_s <= {mr_s[0], main_reset_b};
			eo_r <= eo;
			ee_r <= ee;
			if (reg_wr && reg_addr >= 8'h42 && reg_addr <= 8'h49) begin
				cfg_s[3'(reg_addr - 8'h42)] <= reg_wdata &
					((reg_addr inside {8'h42, 8'h47, 8'h48}) ? 8'h8F : 8'h87);
			end
			// main reset outranks a write in the same cycle
			if (!mr_s[1]) begin
				cfg_s[0] <= 8'h00;
			end
		end
	end

	always_comb begin
		logic [1:0] sel;
		logic       drv;
		logic       val;
		sel = 2'h0;
		drv = 1'b0;
		val = 1'b0;
		for (int i = 0; i < 8; i++) begin
			sel = cfg_s[i][3:2];
			drv = ~cfg_s[i][0];
			val = gpio_write_value[i] ^ cfg_s[i][1];
			if ((sel == 2'h1 && OUT1[i]) || (sel == 2'h2 && i == 0)) begin
				drv = 1'b1;
				val = (sel == 2'h2) ? infrared_transmit : altv[i];
			end
			if ((sel == 2'h1 && IN1[i]) || (sel == 2'h2 && i inside {5, 6})) begin
				drv = 1'b0;
			end
			eo[i] = ~cfg_s[i][7] & val;
			ee[i] = cfg_s[i][7] ? (~val & drv) : drv;
		end
	end

	// ----------------------------------------
	// properties
	// ----------------------------------------
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not zero outside a read answer");
	chk_port8_default: assert property ($rose(rst_b) |-> port8_data_bits == 8'hF0)
		else $error("port 8 not at default after reset");
	chk_pin_enable: assert property (pin_oe == ee_r)
		else $error("pin enable differs from config");
	chk_pin_value: assert property ((pin_out & ee_r) == (eo_r & ee_r))
		else $error("driven pin value differs from config");
	chk_dsr_route: assert property (uart2_data_set_ready_n ==
		($past(cfg_s[1][2]) ? $past(pin_in[1], 3) : 1'b1))
		else $error("data set ready routing wrong");
	chk_cts_route: assert property (uart2_clear_to_send_n ==
		($past(cfg_s[3][2]) ? $past(pin_in[3], 3) : 1'b1))
		else $error("clear to send routing wrong");
	chk_irqc_route: assert property (interrupt_request_input_c ==
		($past(cfg_s[7][2]) ? $past(pin_in[7], 3) : 1'b0))
		else $error("interrupt input c routing wrong");
	chk_edge4_pulse: assert property (edge_irq4_pulse ==
		($past(cfg_s[5][3:2]) == 2'h2 && $past(pin_in[5], 3) != $past(pin_in[5], 4)))
		else $error("edge interrupt 4 pulse wrong");
endmodule : gpio_bank_asserts

`default_nettype wire

// *** bench/board_pins_model.sv ***
/*
 * board_pins_model: board wiring at the configurable pins.
 * Assumes every line has a pull-up; ext_en lets the bench drive a line.
 */
`timescale 1ns/1ps
`default_nettype none

module board_pins_model (
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] ext_val,
	input  wire logic [7:0] ext_en,
	output var  logic [7:0] pin_in
);
	// released and undriven lines float up, never keep the last value
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | ~ext_en));
endmodule : board_pins_model

`default_nettype wire

// *** bench/tb_gpio_pin_config_bank.sv ***
/*
 * tb_gpio_pin_config_bank: self-checking bench of the pin configuration bank.
 * Assumes the board model and the bound checker; expected notes go through a queue.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_gpio_pin_config_bank;
	typedef struct packed {logic [2:0] src; logic [7:0] v;} note_type;
	logic       sys_clk, rst_b, main_reset_b, reg_wr, reg_rd, look, rd_d;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, pin_in, pin_out, pin_oe, gpio_write_value;
	logic [7:0] gpio_read_value, port8_data_bits, ext_val, ext_en, e, w, v, got;
	logic       uart2_transmit, infrared_transmit, uart2_request_to_send_n;
	logic       uart2_terminal_ready_n, indicator_out_first, indicator_out_second;
	logic       uart2_data_set_ready_n, uart2_clear_to_send_n, edge_irq4_pulse;
	logic       edge_irq5_pulse, interrupt_request_input_c;
	logic [3:0] n4, n5;
	int         num_errors, checks, seed;
	note_type   q[$];
	note_type   n;
	logic [7:0] rst_tab [9] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h04, 8'h01, 8'hF0};
	logic [7:0] od_tab [4] = '{8'h00, 8'h02, 8'h80, 8'h82};

	gpio_pin_config_bank uut (.sys_clk, .rst_b, .main_reset_b, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .pin_in, .pin_out, .pin_oe, .gpio_write_value, .gpio_read_value,
		.uart2_transmit, .infrared_transmit, .uart2_request_to_send_n, .uart2_terminal_ready_n,
		.indicator_out_first, .indicator_out_second, .uart2_data_set_ready_n,
		.uart2_clear_to_send_n, .edge_irq4_pulse, .edge_irq5_pulse,
		.interrupt_request_input_c, .port8_data_bits);
	board_pins_model board (.pin_out, .pin_oe, .ext_val, .ext_en, .pin_in);

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// ----------------------------------------
	// monitor: oldest note against what is seen
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (rd_d || look) begin
			n = q.pop_front();
			case (n.src)
				3'h0: got = reg_rdata;
				3'h1: got = pin_oe;
				3'h2: got = pin_out & pin_oe;
				3'h3: got = gpio_read_value;
				3'h4: got = port8_data_bits;
				3'h5: got = {n5, n4};
				default: got = {5'h0, interrupt_request_input_c, uart2_clear_to_send_n,
					uart2_data_set_ready_n};
			endcase
			checks++;
			if (got !== n.v) begin
				num_errors++;
				$display("wrong value at %0t: source %0d got %h want %h", $time, n.src, got, n.v);
			end
		end
		rd_d <= reg_rd;
		if (!rst_b) begin
			n4 <= 4'h0;
			n5 <= 4'h0;
		end else begin
			if (edge_irq4_pulse === 1'b1) n4 <= n4 + 4'h1;
			if (edge_irq5_pulse === 1'b1) n5 <= n5 + 4'h1;
		end
	end

	// ----------------------------------------
	// bus and check tasks
	// ----------------------------------------
	task automatic idle(input int c);
		repeat (c) @(posedge sys_clk);
	endtask : idle

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		q.push_back(note_type'{3'h0, x});
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
	endtask : rd

	task automatic see(input logic [2:0] s, input logic [7:0] x);
		q.push_back(note_type'{s, x});
		look <= 1'b1;
		@(posedge sys_clk);
		look <= 1'b0;
		@(posedge sys_clk);
	endtask : see

	task automatic cfg_all(input logic [7:0] c);
		for (int i = 0; i < 8; i++) wr(8'h42 + 8'(i), c);
	endtask : cfg_all

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict

	initial begin
		repeat (5000) @(posedge sys_clk);
		num_errors++;
		print_verdict();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		seed = 44;
		{rst_b, main_reset_b, reg_wr, reg_rd, look} = 5'h08;
		{reg_addr, reg_wdata, gpio_write_value, ext_val} = 32'h0;
		{uart2_transmit, infrared_transmit, uart2_request_to_send_n} = 3'h0;
		{uart2_terminal_ready_n, indicator_out_first, indicator_out_second} = 3'h0;
		ext_en = 8'hFF;
		idle(6);
		rst_b <= 1'b1;
		idle(3);
		foreach (rst_tab[i]) rd(8'h42 + 8'(i), rst_tab[i]);
		rd(8'h40, 8'h00);
		see(3'h4, 8'hF0);
		$display("test reset values done");
		foreach (rst_tab[i]) begin
			e = 8'($random(seed));
			if (i == 5 || i == 6) e[3] = 1'b0;
			wr(8'h42 + 8'(i), e);
			rd(8'h42 + 8'(i), e & ((i inside {0, 5, 6}) ? 8'h8F : (i == 8) ? 8'hFF : 8'h87));
		end
		see(3'h4, e);
		wr(8'h41, 8'hFF);
		rd(8'h41, 8'h00);
		$display("test register masks done");
		for (int p = 0; p < 2; p++) begin
			cfg_all({6'h0, p[0], 1'b1});
			e = 8'($random(seed));
			ext_val <= e;
			idle(4);
			see(3'h1, 8'h00);
			see(3'h3, p[0] ? ~e : e);
		end
		ext_en <= 8'h00;
		foreach (od_tab[k]) begin
			cfg_all(od_tab[k]);
			w = 8'($random(seed));
			gpio_write_value <= w;
			idle(4);
			v = od_tab[k][1] ? ~w : w;
			see(3'h1, od_tab[k][7] ? ~v : 8'hFF);
			see(3'h2, od_tab[k][7] ? 8'h00 : v);
			see(3'h3, w);
		end
		$display("test pin direction done");
		e = 8'($random(seed));
		ext_val <= e;
		ext_en  <= 8'hFF;
		{uart2_transmit, infrared_transmit, uart2_request_to_send_n, uart2_terminal_ready_n,
			indicator_out_first, indicator_out_second} <= 6'($random(seed));
		cfg_all(8'h05);
		// line level must match the released indicator, or routing on counts an extra edge
		ext_val[6] <= indicator_out_second;
		foreach (od_tab[k]) wr(8'h42 + 8'(2 * k), (k == 3) ? 8'h09 : 8'h04);
		see(3'h1, 8'h35);
		see(3'h2, {2'h0, indicator_out_first, uart2_terminal_ready_n, 1'b0, uart2_request_to_send_n,
			1'b0, uart2_transmit});
		see(3'h6, {5'h0, e[7], e[3], e[1]});
		repeat (3) begin
			ext_val[6] <= ~ext_val[6];
			idle(5);
		end
		see(3'h5, 8'h30);
		ext_val[5] <= indicator_out_first;
		wr(8'h42, 8'h08);
		wr(8'h47, 8'h09);
		wr(8'h48, 8'h05);
		see(3'h2, {1'b0, indicator_out_second, 1'b0, uart2_terminal_ready_n, 1'b0,
			uart2_request_to_send_n, 1'b0, infrared_transmit});
		repeat (2) begin
			ext_val[5] <= ~ext_val[5];
			idle(5);
		end
		see(3'h5, 8'h32);
		gpio_write_value[0] <= ~infrared_transmit;
		wr(8'h42, 8'h0C);
		see(3'h2, {1'b0, indicator_out_second, 1'b0, uart2_terminal_ready_n, 1'b0,
			uart2_request_to_send_n, 1'b0, ~infrared_transmit});
		$display("test alternate functions done");
		wr(8'h5F, 8'h0F);
		wr(8'h4A, 8'h5A);
		wr(8'h42, 8'h85);
		main_reset_b <= 1'b0;
		idle(3);
		main_reset_b <= 1'b1;
		idle(4);
		rd(8'h42, 8'h00);
		rd(8'h4A, 8'h50);
		rd(8'h43, 8'h05);
		rst_b <= 1'b0;
		idle(6);
		rst_b <= 1'b1;
		idle(3);
		rd(8'h4A, 8'hF0);
		rd(8'h48, 8'h04);
		$display("test resets done");
		print_verdict();
	end
endmodule : tb_gpio_pin_config_bank

bind gpio_pin_config_bank gpio_bank_asserts chk (.sys_clk, .rst_b, .main_reset_b, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_in, .pin_out, .pin_oe, .gpio_write_value,
	.uart2_transmit, .infrared_transmit, .uart2_request_to_send_n, .uart2_terminal_ready_n,
	.indicator_out_first, .indicator_out_second, .uart2_data_set_ready_n,
	.uart2_clear_to_send_n, .edge_irq4_pulse, .interrupt_request_input_c, .port8_data_bits);

`default_nettype wire
